// ---- rtl/mode_irq_pkg.sv ----
// Package: offsets, field positions, reset values and mode codes
package mode_irq_pkg;
  // Register byte offsets
  localparam logic [7:0] path_mode_select_off = 8'h08;
  localparam logic [7:0] tx_synth_control_off = 8'h09;
  localparam logic [7:0] irq_source_summary_off = 8'h13;
  localparam logic [7:0] status_base_off = 8'h14;
  localparam logic [7:0] mask_base_off = 8'h15;
  localparam int num_status = 4;
  // Reset values
  localparam logic [7:0] cfg_reset_val = 8'h00;
  // Field positions in tx_synth_control
  localparam int clk_src_lsb = 0;
  localparam int synth_ref_bit = 2;
  localparam int synth_in_lsb = 3;
  localparam int synth_pin_bit = 5;
  localparam int synth_out_lsb = 6;
  // Receive path modes
  typedef enum logic [3:0] {
    rx_t1_d4 = 4'h0, rx_t1_esf = 4'h1, rx_j1_d4 = 4'h2, rx_j1_esf = 4'h3,
    rx_e1_fas = 4'h4, rx_e1_cas = 4'h5, rx_e1_crc4 = 4'h6,
    rx_e1_cas_crc4 = 4'h7, rx_sync_2048 = 4'h8, rx_sync_6312 = 4'hb
  } rx_mode_t;
  // Transmit path modes
  typedef enum logic [3:0] {
    tx_t1_d4 = 4'h0, tx_t1_esf = 4'h1, tx_j1_d4 = 4'h2, tx_j1_esf = 4'h3,
    tx_e1_fas = 4'h4, tx_e1_crc4 = 4'h6, tx_sync_2048 = 4'h8,
    tx_sync_6312 = 4'hb
  } tx_mode_t;
  // Clock source and frequency codes
  localparam logic [1:0] clk_src_ext_pin = 2'h0;
  localparam logic [1:0] clk_src_synth = 2'h1;
  localparam logic [1:0] clk_src_master = 2'h2;
  localparam logic [1:0] clk_src_recovered = 2'h3;
  localparam logic [1:0] freq_1544 = 2'h0;
  localparam logic [1:0] freq_2048 = 2'h1;
  localparam logic [1:0] freq_6312 = 2'h3;
endpackage

// ---- rtl/status_latch.sv ----
// One latched status register with write-one-to-clear select and mask
`timescale 1ns/1ps
module status_latch
  import mode_irq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Event and condition sources
  input wire logic [7:0] event_in,
  input wire logic [7:0] cond_in,
  // Host access
  input wire logic sel_write,
  input wire logic [7:0] sel_data,
  input wire logic mask_we,
  input wire logic [7:0] mask_wdata,
  // Results
  output logic [7:0] status_q,
  output logic [7:0] mask_q,
  output logic active
);
  logic [7:0] latch_reg;
  logic [7:0] latch_next;

  // Selected bits clear on the write before a read; set wins over clear
  always_comb begin
    latch_next = latch_reg;
    if (sel_write) begin
      latch_next = latch_reg & ~sel_data;
    end
    latch_next = latch_next | event_in | cond_in;
  end

  // Latch storage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      latch_reg <= cfg_reset_val;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // Mask storage, cleared at reset so nothing interrupts early
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mask_q <= cfg_reset_val;
    end else if (mask_we) begin
      mask_q <= mask_wdata;
    end
  end

  assign status_q = latch_reg;
  assign active = |(latch_reg & mask_q);
endmodule // status_latch

// ---- rtl/mode_clock_config_and_irq.sv ----
// Mode, transmit synthesiser configuration and interrupt gating
`timescale 1ns/1ps
module mode_clock_config_and_irq
  import mode_irq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Host register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Hardware mode straps (pins)
  input wire logic hw_mode_pin,
  input wire logic [3:0] rx_path_mode_pin,
  input wire logic [3:0] tx_path_mode_pin,
  input wire logic [1:0] tx_clock_source_pin,
  // Status sources, four registers of eight bits
  input wire logic [31:0] status_events,
  input wire logic [31:0] status_conds,
  // Decoded configuration
  output logic [3:0] rx_path_mode,
  output logic [3:0] tx_path_mode,
  output logic [1:0] tx_clock_source,
  output logic synth_reference_sel,
  output logic [1:0] synth_input_freq,
  output logic synth_pin_route,
  output logic [1:0] synth_output_freq,
  output logic rx_mode_reserved,
  output logic tx_mode_reserved,
  output logic tx_cas_external,
  // Interrupt
  output logic irq_out
);
  logic [7:0] path_mode_select_reg;
  logic [7:0] tx_synth_control_reg;
  logic [1:0] hw_mode_sync;
  logic [7:0] mode_pin_s1;
  logic [7:0] mode_pin_s2;
  logic [1:0] clk_pin_s1;
  logic [1:0] clk_pin_s2;
  logic [7:0] mode_eff;
  logic [7:0] synth_eff;
  logic [3:0] summary;
  logic [7:0] status_q [num_status];
  logic [7:0] mask_q [num_status];
  logic [7:0] rdata_next;

  // Pins come from outside; two flops before use
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hw_mode_sync <= 2'h0;
      mode_pin_s1 <= 8'h00;
      mode_pin_s2 <= 8'h00;
      clk_pin_s1 <= 2'h0;
      clk_pin_s2 <= 2'h0;
    end else begin
      hw_mode_sync <= {hw_mode_sync[0], hw_mode_pin};
      mode_pin_s1 <= {tx_path_mode_pin, rx_path_mode_pin};
      mode_pin_s2 <= mode_pin_s1;
      clk_pin_s1 <= tx_clock_source_pin;
      clk_pin_s2 <= clk_pin_s1;
    end
  end

  // Configuration registers, cleared by reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      path_mode_select_reg <= cfg_reset_val;
      tx_synth_control_reg <= cfg_reset_val;
    end else if (reg_wr) begin
      if (reg_addr == path_mode_select_off) begin
        path_mode_select_reg <= reg_wdata;
      end
      if (reg_addr == tx_synth_control_off) begin
        tx_synth_control_reg <= reg_wdata;
      end
    end
  end

  // Hardware mode overrides software configuration
  always_comb begin
    if (hw_mode_sync[1]) begin
      mode_eff = mode_pin_s2;
      synth_eff = {6'h00, clk_pin_s2};
    end else begin
      mode_eff = path_mode_select_reg;
      synth_eff = tx_synth_control_reg;
    end
  end

  // Four status/mask pairs
  for (genvar i = 0; i < num_status; i++) begin : g_status
    status_latch u_status (
      .core_clk(core_clk),
      .srst(srst),
      .event_in(status_events[8*i +: 8]),
      .cond_in(status_conds[8*i +: 8]),
      .sel_write(reg_wr &&
                 reg_addr == status_base_off + 8'(2*i)),
      .sel_data(reg_wdata),
      .mask_we(reg_wr && !hw_mode_sync[1] &&
               reg_addr == mask_base_off + 8'(2*i)),
      .mask_wdata(reg_wdata),
      .status_q(status_q[i]),
      .mask_q(mask_q[i]),
      .active(summary[i])
    );
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr == path_mode_select_off) begin
      rdata_next = mode_eff;
    end else if (reg_addr == tx_synth_control_off) begin
      rdata_next = synth_eff;
    end else if (reg_addr == irq_source_summary_off) begin
      rdata_next = {4'h0, summary};
    end
    for (int k = 0; k < num_status; k++) begin
      if (reg_addr == status_base_off + 8'(2*k)) begin
        rdata_next = status_q[k];
      end
      if (reg_addr == mask_base_off + 8'(2*k)) begin
        rdata_next = mask_q[k];
      end
    end
  end

  // Read data registered on the read strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // Mode decode outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_path_mode <= 4'h0;
      tx_path_mode <= 4'h0;
      rx_mode_reserved <= 1'b0;
      tx_mode_reserved <= 1'b0;
      tx_cas_external <= 1'b0;
    end else begin
      rx_path_mode <= mode_eff[3:0];
      tx_path_mode <= mode_eff[7:4];
      rx_mode_reserved <= mode_eff[3:0] == 4'h9 || mode_eff[3:0] == 4'ha ||
                          mode_eff[3:0] >= 4'hc;
      tx_mode_reserved <= !(mode_eff[7:4] <= 4'h4 ||
                            mode_eff[7:4] == 4'h6 ||
                            mode_eff[7:4] == 4'h8 ||
                            mode_eff[7:4] == 4'hb);
      // No internal CAS source; data must carry it in E1 framing
      tx_cas_external <= mode_eff[7:4] == tx_e1_fas ||
                         mode_eff[7:4] == tx_e1_crc4;
    end
  end

  // Synthesiser control outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_clock_source <= clk_src_ext_pin;
      synth_reference_sel <= 1'b0;
      synth_input_freq <= freq_1544;
      synth_pin_route <= 1'b0;
      synth_output_freq <= freq_1544;
    end else begin
      tx_clock_source <= synth_eff[clk_src_lsb +: 2];
      synth_reference_sel <= synth_eff[synth_ref_bit];
      synth_input_freq <= synth_eff[synth_in_lsb +: 2];
      synth_pin_route <= synth_eff[synth_pin_bit];
      synth_output_freq <= synth_eff[synth_out_lsb +: 2];
    end
  end

  // Interrupt only from masked status bits
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |summary;
    end
  end
endmodule // mode_clock_config_and_irq

// ---- testbench/mode_irq_asserts.sv ----
// Checker for mode decode, synth fields and interrupt gating
`timescale 1ns/1ps
module mode_irq_asserts (
  // Clock, reset, host port and hardware mode strap
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic hw_mode_pin,
  // Decoded outputs
  input wire logic [3:0] rx_path_mode,
  input wire logic [3:0] tx_path_mode,
  input wire logic [1:0] tx_clock_source,
  input wire logic synth_reference_sel,
  input wire logic [1:0] synth_input_freq,
  input wire logic synth_pin_route,
  input wire logic [1:0] synth_output_freq,
  input wire logic rx_mode_reserved,
  input wire logic tx_mode_reserved,
  input wire logic tx_cas_external,
  input wire logic irq_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Synth bits 7:2 as one value
  wire [5:0] syn = {synth_output_freq, synth_pin_route, synth_input_freq,
    synth_reference_sel};
  AST_RST: assert property (
    disable iff (1'b0) srst |=> !irq_out && syn == 6'h00)
    else $error("reset values");
  // Masks stay clear until a write, so no interrupt can show
  AST_NOIRQ: assert property (
    disable iff (1'b0) srst ##1 !reg_wr [*3] |-> !irq_out)
    else $error("irq without mask");
  // Strap passes two flops, so the pin must be low a cycle early
  AST_MODE: assert property (
    !hw_mode_pin ##1 (reg_wr && reg_addr == 8'h08) |=> ##1
    {tx_path_mode, rx_path_mode} == $past(reg_wdata, 2))
    else $error("mode nibbles");
  AST_CLK: assert property (
    !hw_mode_pin ##1 (reg_wr && reg_addr == 8'h09) |=> ##1
    tx_clock_source == $past(reg_wdata[1:0], 2))
    else $error("clock source");
  AST_SYN: assert property (
    !hw_mode_pin ##1 (reg_wr && reg_addr == 8'h09) |=> ##1
    syn == $past(reg_wdata[7:2], 2))
    else $error("synth fields");
  AST_RXRES: assert property (
    rx_mode_reserved == (rx_path_mode inside {4'h9, 4'ha, [4'hc:4'hf]}))
    else $error("rx reserved");
  AST_TXRES: assert property (
    tx_mode_reserved ==
    !(tx_path_mode inside {[4'h0:4'h4], 4'h6, 4'h8, 4'hb}))
    else $error("tx reserved");
  AST_CAS: assert property (
    tx_cas_external == (tx_path_mode inside {4'h4, 4'h6}))
    else $error("cas external");
  AST_HW: assert property (
    hw_mode_pin [*6] |-> syn == 6'h00)
    else $error("hw synth bits");
endmodule // mode_irq_asserts
bind mode_clock_config_and_irq mode_irq_asserts u_chk (.core_clk, .srst,
  .reg_addr, .reg_wr, .reg_wdata, .hw_mode_pin, .rx_path_mode, .tx_path_mode,
  .tx_clock_source, .synth_reference_sel, .synth_input_freq, .synth_pin_route,
  .synth_output_freq, .rx_mode_reserved, .tx_mode_reserved, .tx_cas_external,
  .irq_out);

// ---- testbench/host_model.sv ----
// Host processor model on the register port
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [7:0] reg_addr = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_wdata = 8'h00,
  input wire logic [7:0] reg_rdata
);
  // Write taken at the edge after launch; idle data is inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Read data is sampled mid-cycle, clear of the update edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
endmodule // host_model

// ---- testbench/tb_top.sv ----
// Top bench: mode and synth sweeps, interrupt flow, hardware mode
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic hw_mode_pin = 1'b0;
  logic [3:0] rx_path_mode_pin = 4'h0;
  logic [3:0] tx_path_mode_pin = 4'h0;
  logic [1:0] tx_clock_source_pin = 2'h0;
  logic [31:0] status_events = 32'h0;
  logic [31:0] status_conds = 32'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, d;
  logic reg_wr, reg_rd, synth_reference_sel, synth_pin_route, irq_out;
  logic rx_mode_reserved, tx_mode_reserved, tx_cas_external;
  logic [3:0] rx_path_mode, tx_path_mode;
  logic [1:0] tx_clock_source, synth_input_freq, synth_output_freq;
  int miscompares = 0;
  int cmp_count = 0;
  mode_clock_config_and_irq u_dut (.core_clk, .srst, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .hw_mode_pin, .rx_path_mode_pin,
    .tx_path_mode_pin, .tx_clock_source_pin, .status_events, .status_conds,
    .rx_path_mode, .tx_path_mode, .tx_clock_source, .synth_reference_sel,
    .synth_input_freq, .synth_pin_route, .synth_output_freq,
    .rx_mode_reserved, .tx_mode_reserved, .tx_cas_external, .irq_out);
  host_model u_host (.core_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata);
  always #5 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // Let the launching edge land before sampling
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [7:0] e);
    u_host.rd(a, rv);
    chk(n, e, rv);
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    rdchk("mode", 8'h08, 8'h00);
    rdchk("synth", 8'h09, 8'h00);
    rdchk("unmapped", 8'h21, 8'h00);
    // Every mode code; 6312kHz also sets synth output
    for (int i = 0; i < 16; i++) begin
      u_host.wr(8'h08, {i[3:0], i[3:0]});
      if (i == 11) u_host.wr(8'h09, 8'hc0);
      tick(2);
      chk("modes", {i[3:0], i[3:0]}, {tx_path_mode, rx_path_mode});
      chk("rx rsv", !(16'h09ff >> i & 1), rx_mode_reserved);
      chk("tx rsv", !(16'h095f >> i & 1), tx_mode_reserved);
      chk("cas", i == 4 || i == 6, tx_cas_external);
      if (i == 11) chk("6312 out", 8'h03, synth_output_freq);
    end
    $display("mode test done");
    // Synth fields, undefined frequency code avoided
    for (int j = 0; j < 8; j++) begin
      d = {j[2] & j[1], j[1], j[2], j[1] & j[0], j[0], j[2], j[1:0]};
      u_host.wr(8'h09, d);
      tick(2);
      chk("clk src", d[1:0], tx_clock_source);
      chk("synth", d[7:2], {synth_output_freq, synth_pin_route,
        synth_input_freq, synth_reference_sel});
      rdchk("synth rd", 8'h09, d);
    end
    $display("synth test done");
    @(posedge core_clk);
    status_conds <= 32'h0000_0800;
    tick(3);
    chk("irq masked", 8'h00, irq_out);
    u_host.wr(8'h17, 8'h08);
    tick(3);
    chk("irq set", 8'h01, irq_out);
    rdchk("summary", 8'h13, 8'h02);
    u_host.wr(8'h17, 8'h00);
    tick(3);
    chk("irq quiet", 8'h00, irq_out);
    @(posedge core_clk);
    status_conds <= 32'h0;
    u_host.wr(8'h17, 8'h08);
    tick(3);
    chk("irq latched", 8'h01, irq_out);
    u_host.wr(8'h16, 8'h08);
    tick(3);
    chk("irq clear", 8'h00, irq_out);
    u_host.wr(8'h1b, 8'h80);
    @(posedge core_clk);
    status_events <= 32'h8000_0000;
    @(posedge core_clk);
    status_events <= 32'h0;
    tick(3);
    chk("irq event", 8'h01, irq_out);
    rdchk("summary", 8'h13, 8'h08);
    rdchk("status four", 8'h1a, 8'h80);
    $display("irq test done");
    @(posedge core_clk);
    hw_mode_pin <= 1'b1;
    rx_path_mode_pin <= 4'h5;
    tx_path_mode_pin <= 4'h6;
    tx_clock_source_pin <= 2'h2;
    tick(6);
    chk("hw clk", 8'h02, tx_clock_source);
    rdchk("hw mode", 8'h08, 8'h65);
    @(posedge core_clk);
    hw_mode_pin <= 1'b0;
    tick(6);
    chk("sw modes", 8'hff, {tx_path_mode, rx_path_mode});
    @(posedge core_clk);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    tick(1);
    chk("irq rst", 8'h00, irq_out);
    rdchk("mask rst", 8'h1b, 8'h00);
    $display("hw and reset test done");
    stop_test();
  end
endmodule // tb_top
